//--- inc/sfp_pkg.sv
// Package for the serial flash pin front end: widths, modes, timing, carriers.
// Assumes a 125 MHz system clock that oversamples the host serial clock.
package sfp_pkg;

  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned RESET_PULSE_NS   = 1000;
  // Least time, rounded up to whole cycles.
  localparam int unsigned RESET_PULSE_CYC  =
    (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCLK_MAX_MHZ     = 104;
  localparam int unsigned PAGE_BYTES       = 256;
  localparam int unsigned UID_BITS         = 64;
  localparam int unsigned ADDR_BITS        = 24;
  localparam int unsigned INSTR_BITS       = 8;
  localparam int unsigned MODE_BITS        = 8;
  localparam int unsigned FIFO_DEPTH       = 4;
  localparam logic        PAUSE_SEL_RESET  = 1'b0;
  // Wrap window field: 0=8, 1=16, 2=32, 3=64 bytes.
  localparam logic [1:0]  WRAP_8           = 2'h0;
  localparam logic [1:0]  WRAP_64          = 2'h3;

  typedef enum logic [1:0] {
    SFP_W1,
    SFP_W2,
    SFP_W4
  } sfp_width_t;

  typedef struct packed {
    logic [3:0] in;
    logic [3:0] out;
    logic [3:0] oe;
  } sfp_io_t;

  typedef struct packed {
    logic       block_protect_0;
    logic       block_protect_1;
    logic       block_protect_2;
    logic       top_bottom_select;
    logic       sector_block_select;
    logic       complement_protect;
    logic       status_protect_0;
  } sfp_prot_t;

  typedef struct packed {
    logic                  quad_enable_bit;
    logic                  pause_or_reset_select;
    logic                  four_line_instruction_mode;
    logic                  cont_read;
    logic                  wrap_en;
    logic [1:0]            wrap_size;
  } sfp_cfg_t;

endpackage

//--- rtl/sfp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty come from an occupancy count.
`timescale 1ns/10ps
module sfp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- rtl/sfp_front.sv
// Pin front end of a multi-I/O serial flash: select, edges, hold, reset.
// Assumes the host serial clock is far slower than clk and is oversampled;
// the array, instruction decoder and status register live behind the ports.
//
// Notes on behaviour
// - Single-line input bits are taken on each serial clock rise.
// - Serial output changes on each serial clock fall.
// - Lines zero and one take input on rise, drive read data on fall.
// - Chip select high deselects and floats all data outputs.
// - Only while selected are instructions taken and read data returned.
// - Nothing is accepted until the first chip select fall after power-up.
// - A busy internal cycle carries on after chip select rises.
// - Asserted write protect blocks status register writes when status_protect_0 is set.
// - Write protect joins protect bits to guard parts of the array.
// - Quad mode drops write protect; pin becomes data line two.
// - Shared pin is hold only when select bit is zero; reset value zero.
// - Hold low while selected floats output, ignores clock and data.
// - Hold release resumes the transfer without losing state.
// - Quad enable drops hold; pin becomes data line three.
// - Protect, hold and reset pin functions only in standard and dual.
// - Standard and dual use lines zero, one; quad uses zero to three.
// - Four-line instruction mode moves the instruction in two clocks.
// - Continuous read skips the instruction phase.
// - Reads may wrap in aligned 8, 16, 32 or 64 byte windows.
// - Serial clock up to 104 MHz at every width; here it must stay far below the 125 MHz clk.
// - Up to 256 data bytes per page program.
// - A 64-bit unique value is readable by the host.
// - Select bit one makes the shared pin an active-low reset.
// - Reset low for about one microsecond aborts all operations.
`timescale 1ns/10ps
module sfp_front #(
  parameter int unsigned RESET_CYC = sfp_pkg::RESET_PULSE_CYC,
  parameter logic [sfp_pkg::UID_BITS-1:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             sclk,
  input  wire logic                             cs_n,
  input  wire logic [3:0]                       io_in,
  output logic      [3:0]                       io_out,
  output logic      [3:0]                       io_oe,
  input  wire sfp_pkg::sfp_cfg_t                cfg,
  input  wire sfp_pkg::sfp_prot_t               prot,
  input  wire logic                             read_cmd,
  input  wire sfp_pkg::sfp_width_t              data_width,
  input  wire logic                             uid_cmd,
  input  wire logic                             internal_busy,
  output logic      [sfp_pkg::INSTR_BITS-1:0]   instr,
  output logic                                  instr_valid,
  output logic      [sfp_pkg::ADDR_BITS-1:0]    addr,
  output logic                                  addr_valid,
  output logic      [7:0]                       wr_data,
  output logic                                  wr_valid,
  input  wire logic                             wr_ready,
  output logic                                  wr_overflow,
  input  wire logic [7:0]                       rd_data,
  input  wire logic                             rd_valid,
  output logic                                  rd_ready,
  output logic      [sfp_pkg::ADDR_BITS-1:0]    rd_addr,
  output logic                                  status_write_ok,
  output logic                                  array_hw_lock,
  output logic                                  hw_reset,
  output logic                                  selected,
  output logic                                  busy_hold
);
  typedef enum logic [2:0] {
    SFP_IDLE, SFP_INSTR, SFP_ADDR, SFP_DATA_IN, SFP_READ, SFP_DONE
  } sfp_state_t;

  sfp_state_t   st_q;
  logic [2:0]   sclk_s_q;
  logic [2:0]   cs_s_q;
  logic [2:0]   io3_s_q;
  logic [3:0]   io_m_q;
  logic [3:0]   io_s_q;
  logic         armed_q;
  logic [7:0]   sh_q;
  logic [5:0]   bit_q;
  logic [23:0]  addr_q;
  logic [8:0]   pg_cnt_q;
  logic [7:0]   rd_sh_q;
  logic [5:0]   uid_idx_q;
  logic [3:0]   out_q;
  logic [3:0]   oe_q;
  logic [5:0]   rd_bit_q;
  logic [7:0]   rd_byte;
  logic [31:0]  rst_cnt_q;
  logic         rise;
  logic         fall;
  logic         cs_low;
  logic         cs_fall;
  logic         quad_mode;
  logic         hold_act;
  logic [2:0]   step;
  logic [7:0]   shn;
  logic [7:0]   fifo_q;
  logic         fifo_v;
  logic         fifo_rdy;

  // Count of bits moved per serial clock for a given width.
  function automatic logic [2:0] width_bits(sfp_pkg::sfp_width_t w);
    unique case (w)
      sfp_pkg::SFP_W1: width_bits = 3'h1;
      sfp_pkg::SFP_W2: width_bits = 3'h2;
      sfp_pkg::SFP_W4: width_bits = 3'h4;
      default:         width_bits = 3'h1;
    endcase
  endfunction

  // Shift a byte left by the width, filling from the low input lines.
  function automatic logic [7:0] shift_in(logic [7:0] s, logic [3:0] d,
                                          logic [2:0] n);
    unique case (n)
      3'h4:    shift_in = {s[3:0], d[3:0]};
      3'h2:    shift_in = {s[5:0], d[1:0]};
      default: shift_in = {s[6:0], d[0]};
    endcase
  endfunction

  // Mask of the input lines that carry bits at a given width.
  function automatic logic [3:0] lane_mask(logic [2:0] n);
    lane_mask = 4'((5'h1 << n) - 5'h1);
  endfunction

  // oversampled serial pins
  // Three-stage sync on clock, select and line three (data lines two); select and line three count once stages two and three agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 3'h7;
      io3_s_q  <= 3'h7;
      io_m_q   <= 4'h0;
      io_s_q   <= 4'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q   <= {cs_s_q[1:0], cs_n};
      io3_s_q  <= {io3_s_q[1:0], io_in[3]};
      io_m_q   <= io_in;
      io_s_q   <= io_m_q;
    end
  end

  // Clock edges use only the second and third stages; select fall also reads the first.
  assign rise    = sclk_s_q[1] && !sclk_s_q[2];
  assign fall    = !sclk_s_q[1] && sclk_s_q[2];
  assign cs_low  = !cs_s_q[1] && !cs_s_q[2];
  assign cs_fall = !cs_s_q[1] && !cs_s_q[2] && cs_s_q[0] == 1'b0
                   && armed_q == 1'b0;
  assign quad_mode = cfg.quad_enable_bit || cfg.four_line_instruction_mode;
  assign hold_act = !quad_mode && !cfg.pause_or_reset_select
                    && cs_low && !io3_s_q[1] && !io3_s_q[2];
  assign busy_hold = hold_act;
  assign selected  = cs_low && armed_q;
  assign step = (st_q == SFP_INSTR && cfg.four_line_instruction_mode) ?
                3'h4 : (st_q == SFP_INSTR) ? 3'h1 : width_bits(data_width);
  assign shn  = shift_in(sh_q, io_s_q, step);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (hw_reset) begin
      armed_q <= 1'b0;
    end else if (cs_fall) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_cnt_q <= 32'h0;
      hw_reset  <= 1'b0;
    end else if (!quad_mode && cfg.pause_or_reset_select
                 && !io3_s_q[1] && !io3_s_q[2]) begin
      if (rst_cnt_q < 32'(RESET_CYC)) begin
        rst_cnt_q <= rst_cnt_q + 32'h1;
      end
      hw_reset <= (rst_cnt_q >= 32'(RESET_CYC) - 32'h1);
    end else begin
      rst_cnt_q <= 32'h0;
      hw_reset  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_write_ok <= 1'b1;
      array_hw_lock   <= 1'b0;
    end else begin
      status_write_ok <= quad_mode || !prot.status_protect_0 || io_s_q[2];
      array_hw_lock   <= !quad_mode && prot.status_protect_0 && !io_s_q[2]
                         && (prot.block_protect_0 || prot.block_protect_1
                             || prot.block_protect_2
                             || prot.complement_protect);
    end
  end

  // Transaction state machine; hold freezes every register except the instr_valid and addr_valid strobes, which still clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q        <= SFP_IDLE;
      sh_q        <= 8'h0;
      bit_q       <= 6'h0;
      addr_q      <= 24'h0;
      pg_cnt_q    <= 9'h0;
      instr       <= 8'h0;
      instr_valid <= 1'b0;
      addr_valid  <= 1'b0;
      wr_overflow <= 1'b0;
    end else begin
      instr_valid <= 1'b0;
      addr_valid  <= 1'b0;
      if (!cs_low || !armed_q || hw_reset) begin
        st_q     <= (cs_low && armed_q) ? SFP_DONE : SFP_IDLE;
        bit_q    <= 6'h0;
        pg_cnt_q <= 9'h0;
        if (!cs_low) begin
          st_q <= SFP_IDLE;
        end
      end else if (!hold_act && rise) begin
        sh_q <= shn;
        unique case (st_q)
          SFP_IDLE: begin
            st_q  <= cfg.cont_read ? SFP_ADDR : SFP_INSTR;
            addr_q <= 24'(io_s_q & lane_mask(width_bits(data_width)));
            sh_q  <= shift_in(8'h0, io_s_q,
                       cfg.cont_read ? width_bits(data_width) :
                       cfg.four_line_instruction_mode ? 3'h4 : 3'h1);
            bit_q <= 6'(cfg.cont_read ? width_bits(data_width) :
                       cfg.four_line_instruction_mode ? 3'h4 : 3'h1);
          end
          SFP_INSTR: begin
            if (bit_q + 6'(step) >= 6'd8) begin
              instr       <= shn;
              instr_valid <= 1'b1;
              st_q        <= SFP_ADDR;
              bit_q       <= 6'h0;
            end else begin
              bit_q <= bit_q + 6'(step);
            end
          end
          SFP_ADDR: begin
            addr_q <= (addr_q << step) | 24'(io_s_q & lane_mask(step));
            if (bit_q + 6'(step) >= 6'd24) begin
              addr_valid <= 1'b1;
              st_q  <= read_cmd ? SFP_READ : SFP_DATA_IN;
              bit_q <= 6'h0;
            end else begin
              bit_q <= bit_q + 6'(step);
            end
          end
          SFP_DATA_IN: begin
            if (bit_q + 6'(step) >= 6'd8) begin
              bit_q <= 6'h0;
              if (pg_cnt_q == 9'(sfp_pkg::PAGE_BYTES) || !fifo_rdy) begin
                wr_overflow <= 1'b1;
              end else begin
                pg_cnt_q <= pg_cnt_q + 9'h1;
              end
            end else begin
              bit_q <= bit_q + 6'(step);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign addr = addr_q;

  // Write bytes flow through the FIFO; a full FIFO flags overflow.
  assign fifo_q = shn;
  assign fifo_v = cs_low && armed_q && !hold_act && rise
                  && st_q == SFP_DATA_IN && bit_q + 6'(step) >= 6'd8
                  && pg_cnt_q != 9'(sfp_pkg::PAGE_BYTES);

  sfp_fifo #(
    .WIDTH (8),
    .DEPTH (sfp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (hw_reset),
    .in_data   (fifo_q),
    .in_valid  (fifo_v),
    .in_ready  (fifo_rdy),
    .out_data  (wr_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_addr <= 24'h0;
    end else if (addr_valid) begin
      rd_addr <= addr_q;
    end else if (rd_ready && rd_valid) begin
      if (cfg.wrap_en) begin
        unique case (cfg.wrap_size)
          2'h0: rd_addr[2:0] <= rd_addr[2:0] + 3'h1;
          2'h1: rd_addr[3:0] <= rd_addr[3:0] + 4'h1;
          2'h2: rd_addr[4:0] <= rd_addr[4:0] + 5'h1;
          2'h3: rd_addr[5:0] <= rd_addr[5:0] + 6'h1;
        endcase
      end else begin
        rd_addr <= rd_addr + 24'h1;
      end
    end
  end

  assign rd_ready = cs_low && armed_q && !hold_act && fall
                    && st_q == SFP_READ && rd_bit_q == 6'h0;

  assign rd_byte = uid_cmd ? UNIQUE_ID[63 - {uid_idx_q[5:3], 3'h0} -: 8]
                           : rd_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_sh_q   <= 8'h0;
      uid_idx_q <= 6'h0;
      out_q     <= 4'h0;
      oe_q      <= 4'h0;
    end else if (!cs_low || st_q != SFP_READ || hw_reset) begin
      oe_q      <= 4'h0;
      uid_idx_q <= 6'h0;
    end else if (!hold_act && fall) begin
      if (rd_bit_q == 6'h0) begin
        rd_sh_q   <= rd_byte << step;
        uid_idx_q <= uid_idx_q + 6'h8;
      end else begin
        rd_sh_q <= rd_sh_q << step;
      end
      unique case (step)
        3'h4: begin
          out_q <= (rd_bit_q == 6'h0) ? rd_byte[7:4] : rd_sh_q[7:4];
          oe_q  <= 4'hf;
        end
        3'h2: begin
          out_q <= {2'h0, (rd_bit_q == 6'h0) ? rd_byte[7:6] : rd_sh_q[7:6]};
          oe_q  <= 4'h3;
        end
        default: begin
          out_q <= {2'h0, (rd_bit_q == 6'h0) ? rd_byte[7] : rd_sh_q[7], 1'b0};
          oe_q  <= 4'h2;
        end
      endcase
    end
  end

  // Read bit count moves on fall only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_bit_q <= 6'h0;
    end else if (!cs_low || st_q != SFP_READ) begin
      rd_bit_q <= 6'h0;
    end else if (!hold_act && fall) begin
      rd_bit_q <= (rd_bit_q + 6'(step) >= 6'd8) ? 6'h0 : rd_bit_q + 6'(step);
    end
  end

  assign io_out = out_q;
  // float under deselect, hold, unused lanes
  assign io_oe  = (cs_low && !hold_act)
                  ? (oe_q & (quad_mode ? 4'hf : 4'h3)) : 4'h0;
endmodule

//--- tb/sfp_monitor.sv
// Checker of the flash pin front end, bound into every sfp_front.
// Assumes the serial pins are oversampled by clk through short synchronisers.
`timescale 1ns/10ps
module sfp_monitor #(
  parameter int unsigned RESET_CYC = 4
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               sclk,
  input wire logic               cs_n,
  input wire logic         [3:0] io_in,
  input wire logic         [3:0] io_out,
  input wire logic         [3:0] io_oe,
  input wire sfp_pkg::sfp_cfg_t  cfg,
  input wire sfp_pkg::sfp_prot_t prot,
  input wire logic               read_cmd,
  input wire logic               instr_valid,
  input wire logic               addr_valid,
  input wire logic               wr_overflow,
  input wire logic               status_write_ok,
  input wire logic               hw_reset,
  input wire logic               selected,
  input wire logic               busy_hold
);
  logic std_mode;
  assign std_mode = !cfg.quad_enable_bit && !cfg.four_line_instruction_mode;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  desel_float_a: assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("data lines driven while deselected");
  read_drive_a: assert property (|io_oe |-> read_cmd)
    else $error("data lines driven outside a read");
  std_lanes_a: assert property (std_mode |-> io_oe[3:2] == 2'h0)
    else $error("upper lanes driven in standard or dual mode");
  hold_float_a: assert property (busy_hold |-> io_oe == 4'h0)
    else $error("output driven during hold");
  hold_mode_a: assert property (busy_hold |->
    std_mode && !cfg.pause_or_reset_select)
    else $error("hold active outside its mode");
  reset_mode_a: assert property (hw_reset |->
    std_mode && cfg.pause_or_reset_select)
    else $error("reset pin active outside its mode");
  reset_len_a: assert property ($rose(hw_reset) |->
    $past(io_in[3], RESET_CYC) == 1'b0)
    else $error("reset taken from a short pulse");
  sel_only_a: assert property (
    instr_valid || addr_valid |-> selected)
    else $error("transfer taken while deselected");
  wp_block_a: assert property (
    (std_mode && prot.status_protect_0 && !io_in[2]) [*6]
    |-> !status_write_ok)
    else $error("status write allowed under write protect");
  quad_nowp_a: assert property (
    cfg.quad_enable_bit [*6] |-> status_write_ok)
    else $error("write protect active in quad mode");
  fall_change_a: assert property (
    selected && |io_oe && $changed(io_out) |-> !sclk)
    else $error("output changed while serial clock high");
  cover property (instr_valid);
  cover property (busy_hold);
  cover property (hw_reset);
  cover property (wr_overflow);
endmodule

bind sfp_front sfp_monitor #(.RESET_CYC(RESET_CYC)) sfp_monitor_i (
  .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .cfg(cfg), .prot(prot),
  .read_cmd(read_cmd), .instr_valid(instr_valid), .addr_valid(addr_valid),
  .wr_overflow(wr_overflow), .status_write_ok(status_write_ok),
  .hw_reset(hw_reset), .selected(selected), .busy_hold(busy_hold));

//--- tb/sfp_host.sv
// Host controller model: serial clock, select and data lines.
// Assumes the bench calls its tasks; released lines show a toggling pattern.
`timescale 1ns/10ps
module sfp_host (
  input  wire logic       clk,
  input  wire logic       quad,
  input  wire logic       wp_n,
  input  wire logic       hold_n,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] io_in
);
  logic [3:0] en   = 4'h0;
  logic [3:0] dq   = 4'h0;
  logic [3:0] pat  = 4'h5;
  logic [3:0] pin;
  int         half = 8;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  always @(posedge clk) pat <= ~pat;
  assign pin = quad ? 4'h0 : 4'hc;
  assign io_in = (en & dq) | (~en & pin & {hold_n, wp_n, 2'h0})
    | (~en & ~pin & ((io_oe & io_out) | (~io_oe & pat)));

  task automatic sel();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (half) @(posedge clk);
  endtask

  task automatic desel();
    repeat (half) @(posedge clk);
    en   <= 4'h0;
    cs_n <= 1'b1;
    repeat (2 * half) @(posedge clk);
  endtask

  task automatic shift(input int n, input int w, input logic drv,
                       input logic [31:0] v, output logic [31:0] res);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    res = 32'h0;
    for (int i = 0; i < n; i++) begin
      en <= drv ? m : 4'h0;
      dq <= 4'(v >> ((n - 1 - i) * w)) & m;
      repeat (half) @(posedge clk);
      sclk <= 1'b1;
      res = (res << w) | 32'((w == 1) ? {3'h0, io_in[1]} : io_in & m);
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask
endmodule

//--- tb/tb.sv
// Bench of the flash pin front end with host model and bound checker.
// Assumes a 125 MHz clock; the reset pin count is cut to 4 cycles.
`timescale 1ns/10ps
module tb;
  // Arbitrary identification value.
  localparam logic [63:0] UID = 64'h5a3c_9617_e248_b10d;
  logic                clk, rst, sclk, cs_n, quad, wp_n, hold_n;
  logic                read_cmd, want_rd, uid_cmd, busy_in, wr_ready;
  logic                instr_valid, addr_valid, wr_valid, wr_overflow;
  logic                swok, hw_reset, selected, busy_hold, lock;
  logic          [3:0] io_in, io_out, io_oe;
  logic          [7:0] instr, wr_data, rd_data, op, got_instr;
  logic         [23:0] addr, rd_addr, a, got_addr;
  logic         [31:0] r;
  logic          [7:0] q [$];
  sfp_pkg::sfp_cfg_t   cfg;
  sfp_pkg::sfp_prot_t  prot;
  sfp_pkg::sfp_width_t data_width;
  int                  error_cnt, checks_done, n_instr, n0, cyc, w;

  sfp_front #(.RESET_CYC(4), .UNIQUE_ID(UID)) sfp_front_i (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .cfg(cfg), .prot(prot),
    .read_cmd(read_cmd), .data_width(data_width), .uid_cmd(uid_cmd),
    .internal_busy(busy_in), .instr(instr), .instr_valid(instr_valid),
    .addr(addr), .addr_valid(addr_valid), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_overflow(wr_overflow),
    .rd_data(rd_data), .rd_valid(1'b1), .rd_ready(), .rd_addr(rd_addr),
    .status_write_ok(swok), .array_hw_lock(lock), .hw_reset(hw_reset),
    .selected(selected), .busy_hold(busy_hold));

  sfp_host sfp_host_i (
    .clk(clk), .quad(quad), .wp_n(wp_n), .hold_n(hold_n), .io_out(io_out),
    .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n), .io_in(io_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (instr_valid === 1'b1) begin
      got_instr <= instr;
      n_instr   <= n_instr + 1;
    end
    if (addr_valid === 1'b1) got_addr <= addr;
    read_cmd <= (selected !== 1'b1) ? 1'b0 :
      (instr_valid === 1'b1 || cfg.cont_read) ? want_rd : read_cmd;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Any block protect or complement bit guards part of the array.
  function automatic logic lock_exp(sfp_pkg::sfp_prot_t p);
    return p.block_protect_0 | p.block_protect_1 | p.block_protect_2
           | p.complement_protect;
  endfunction

  task automatic pick();
    @(posedge clk);
    op = 8'($urandom);
    a  = 24'($urandom);
    rd_data <= 8'($urandom);
  endtask

  task automatic mode(input logic qe, input logic fl, input int k);
    @(posedge clk);
    cfg.quad_enable_bit <= qe;
    cfg.four_line_instruction_mode <= fl;
    quad <= qe | fl;
    data_width <= sfp_pkg::sfp_width_t'(k);
  endtask

  task automatic xfer(input int iw, input int wd, input logic rd);
    want_rd <= rd;
    sfp_host_i.sel();
    if (iw > 0) sfp_host_i.shift(8 / iw, iw, 1'b1, 32'(op), r);
    sfp_host_i.shift(24 / wd, wd, 1'b1, 32'(a), r);
    if (iw > 0) check("instr", 32'(got_instr), 32'(op));
    check("addr", 32'(got_addr), 32'(a));
    if (rd) begin
      sfp_host_i.shift(8 / wd, wd, 1'b0, 32'h0, r);
      check("read", r, 32'(uid_cmd ? UID[63:56] : rd_data));
    end
  endtask

  initial begin
    rst = 1'b1;
    cfg = '0;
    prot = '0;
    data_width = sfp_pkg::SFP_W1;
    {quad, want_rd, uid_cmd, busy_in, wr_ready} = 5'h0;
    {wp_n, hold_n} = 2'h3;
    rd_data = 8'h0;
    op = 8'($urandom(31));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("oe", 32'(io_oe), 32'h0);
    sfp_host_i.shift(8, 1, 1'b1, 32'(op), r);
    check("early", 32'(n_instr), 32'h0);
    $display("test idle done");
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 1 : (k == 1) ? 2 : 4;
      mode(k > 1, k == 3, (k > 2) ? 2 : k);
      pick();
      busy_in <= 1'(k);
      sfp_host_i.half = 7 + k;
      xfer((k == 3) ? 4 : 1, w, 1'b1);
      sfp_host_i.desel();
    end
    mode(0, 0, 0);
    pick();
    uid_cmd <= 1'b1;
    xfer(1, 1, 1'b1);
    sfp_host_i.desel();
    uid_cmd <= 1'b0;
    $display("test widths done");
    for (int k = 0; k < 5; k++) begin
      pick();
      a = a | 24'h3f;
      cfg.wrap_en <= (k < 4);
      cfg.wrap_size <= 2'(k);
      xfer(1, 1, 1'b1);
      sfp_host_i.shift(8, 1, 1'b0, 32'h0, r);
      w = (k < 4) ? 3 + k : 3;
      check("wrap", 32'(rd_addr >> w), 32'(a >> w) + ((k < 4) ? 0 : 1));
      sfp_host_i.desel();
    end
    mode(1, 0, 2);
    pick();
    cfg.cont_read <= 1'b1;
    n0 = n_instr;
    xfer(0, 4, 1'b0);
    check("skip", 32'(n_instr - n0), 32'h0);
    sfp_host_i.desel();
    cfg.cont_read <= 1'b0;
    $display("test wrap done");
    mode(0, 0, 0);
    pick();
    want_rd <= 1'b0;
    sfp_host_i.sel();
    sfp_host_i.shift(4, 1, 1'b1, 32'(op[7:4]), r);
    hold_n <= 1'b0;
    repeat (8) @(posedge clk);
    check("hold", 32'(busy_hold), 32'h1);
    sfp_host_i.shift(3, 1, 1'b1, 32'h5, r);
    hold_n <= 1'b1;
    repeat (8) @(posedge clk);
    sfp_host_i.shift(4, 1, 1'b1, 32'(op[3:0]), r);
    sfp_host_i.shift(24, 1, 1'b1, 32'(a), r);
    check("resume", 32'(got_instr), 32'(op));
    sfp_host_i.desel();
    prot <= sfp_pkg::sfp_prot_t'(7'($urandom) | 7'h1);
    wp_n <= 1'b0;
    repeat (8) @(posedge clk);
    check("wp", 32'(swok), 32'h0);
    check("lock", 32'(lock), 32'(lock_exp(prot)));
    mode(1, 0, 2);
    repeat (8) @(posedge clk);
    check("wpquad", 32'(swok), 32'h1);
    check("lockquad", 32'(lock), 32'h0);
    mode(0, 0, 0);
    wp_n <= 1'b1;
    $display("test hold done");
    cfg.pause_or_reset_select <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      cfg.pause_or_reset_select <= (k < 2);
      hold_n <= 1'b0;
      repeat ((k == 0) ? 2 : 12) @(posedge clk);
      check("rstpin", 32'(hw_reset), 32'(k == 1));
      hold_n <= 1'b1;
      repeat (10) @(posedge clk);
    end
    check("rstoff", 32'(hw_reset), 32'h0);
    $display("test reset done");
    pick();
    xfer(1, 1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      q.push_back(8'($urandom));
      sfp_host_i.shift(8, 1, 1'b1, 32'(q[i]), r);
      check("full", 32'(wr_overflow), 32'(i == 4));
    end
    for (int i = 0; i < 4; i++) begin
      check("drain", 32'({wr_valid, wr_data}), 32'({1'b1, q[i]}));
      wr_ready <= 1'b1;
      @(posedge clk);
      wr_ready <= 1'b0;
      @(posedge clk);
    end
    check("empty", 32'(wr_valid), 32'h0);
    sfp_host_i.desel();
    $display("test fifo done");
    test_done();
  end
endmodule
